// File: slcd_top.sv
/*
  slcd_top: serial-loaded lcd segment driver with latch and backplane.
  assumes: all pins are asynchronous to CLK and slow against 100 MHz;
  pin edges are recovered from the synchronised levels.
*/
// Contract
// - shifting happens only while chip select is low
// - falling shift clock captures data in and moves stages toward last
// - serial out takes the last stage on rising shift clock
// - latch transparent while load high, holds while load low
// - falling load captures shift register and keeps it
// - chip select falling with shift clock low gives one extra shift
// - latched one drives segment in antiphase with backplane
// - latched zero drives segment in phase with backplane
// - internal mode divides the oscillator by 256 for backplane
// - external mode: each input cycle resets divider, backplane follows
// - static mode drives steady dc levels with no alternation
`timescale 1ns/10ps
`default_nettype none

module slcd_top #(
  parameter int unsigned SEGS = slcd_pkg::SLCD_SEG_DEFAULT
) (
  // clock and reset
  input  wire logic            CLK,
  input  wire logic            RST,
  // serial load pins
  input  wire logic            SERIAL_IN,
  input  wire logic            SHIFT_CLK,
  input  wire logic            CHIP_SEL_N,
  input  wire logic            LOAD,
  output logic                 SERIAL_OUT,
  // backplane timing
  input  wire logic            OSC_TICK,
  input  wire logic            BACKPLANE_CLOCK_IN,
  input  wire logic [1:0]      OSCILLATOR_STRAP,
  // display drive
  output logic                 BACKPLANE_OUT,
  output logic [SEGS-1:0]      SEG_OUT
);

  initial begin
    if (SEGS < 1) begin
      $error("SEGS must be at least one");
    end
  end

  // ----------------------------------------------------------------
  // pin synchronisers
  // ----------------------------------------------------------------
  logic [5:0] pins_sync;
  logic       din_s;
  logic       sclk_s;
  logic       cs_n_s;
  logic       load_s;
  logic       osc_s;
  logic       bpin_s;

  slcd_sync #(
    .WIDTH (6)
  ) u_sync (
    .clk      (CLK),
    .rst      (RST),
    .rst_val  (6'h06),
    .pin_in   ({BACKPLANE_CLOCK_IN, OSC_TICK, LOAD, CHIP_SEL_N,
                SHIFT_CLK, SERIAL_IN}),
    .pin_sync (pins_sync)
  );

  assign din_s  = pins_sync[0];
  assign sclk_s = pins_sync[1];
  assign cs_n_s = pins_sync[2];
  assign load_s = pins_sync[3];
  assign osc_s  = pins_sync[4];
  assign bpin_s = pins_sync[5];

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [SEGS-1:0]                        shift_stage;
    logic [SEGS-1:0]                        latch;
    logic                                   sout;
    logic                                   sclk_d;
    logic                                   cs_n_d;
    logic                                   osc_d;
    logic                                   bpin_d;
    logic [slcd_pkg::SLCD_DIV_WIDTH-1:0]    div;
    logic                                   bp;
    logic [SEGS-1:0]                        seg;
  } slcd_state_s;

  slcd_state_s st_ff;
  slcd_state_s nxt_st;
  slcd_pkg::slcd_mode_e mode;

  logic sclk_fall;
  logic sclk_rise;
  logic cs_fall;
  logic do_shift;
  logic osc_rise;
  logic bpin_rise;

  assign mode      = slcd_pkg::slcd_mode_e'(OSCILLATOR_STRAP);
  assign sclk_fall = st_ff.sclk_d & ~sclk_s;
  assign sclk_rise = ~st_ff.sclk_d & sclk_s;
  assign cs_fall   = st_ff.cs_n_d & ~cs_n_s;
  assign osc_rise  = ~st_ff.osc_d & osc_s;
  assign bpin_rise = ~st_ff.bpin_d & bpin_s;

  // a select edge with the clock low counts as one falling clock edge
  assign do_shift = (~cs_n_s & sclk_fall)
                  | (cs_fall & ~sclk_s);

  always_comb begin
    nxt_st        = st_ff;
    nxt_st.sclk_d = sclk_s;
    nxt_st.cs_n_d = cs_n_s;
    nxt_st.osc_d  = osc_s;
    nxt_st.bpin_d = bpin_s;

    // --------------------------------------------------------------
    // shift register and serial out
    // --------------------------------------------------------------
    if (do_shift) begin
      nxt_st.shift_stage = (st_ff.shift_stage << 1)
                         | SEGS'(din_s);
    end
    if (sclk_rise && !cs_n_s) begin
      nxt_st.sout = st_ff.shift_stage[SEGS-1];
    end

    // latch follows while load high; last value kept at its fall
    if (load_s) begin
      nxt_st.latch = st_ff.shift_stage;
    end

    // --------------------------------------------------------------
    // backplane divider
    // --------------------------------------------------------------
    unique case (mode)
      slcd_pkg::SLCD_MODE_INT: begin
        if (osc_rise) begin
          // top divider bit is the backplane: one full period per 256 ticks
          nxt_st.div = st_ff.div + 8'h01;
          nxt_st.bp  = nxt_st.div[7];
        end
      end
      slcd_pkg::SLCD_MODE_EXT: begin
        if (bpin_rise) begin
          nxt_st.div = slcd_pkg::SLCD_DIV_RESET;
        end
        nxt_st.bp = bpin_s;
      end
      default: begin
        nxt_st.div = slcd_pkg::SLCD_DIV_RESET;
        nxt_st.bp  = 1'b0;
      end
    endcase

    // --------------------------------------------------------------
    // segment drive
    // --------------------------------------------------------------
    nxt_st.seg = st_ff.latch ^ {SEGS{nxt_st.bp}};
  end

  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      st_ff <= '0;
      st_ff.sclk_d <= 1'b1;
      st_ff.cs_n_d <= slcd_pkg::SLCD_CS_RESET;
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign SERIAL_OUT    = st_ff.sout;
  assign BACKPLANE_OUT = st_ff.bp;
  assign SEG_OUT       = st_ff.seg;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  chk_shift_needs_sel: assert property (@(posedge CLK) disable iff (RST)
    (cs_n_s && $past(cs_n_s)) |=> $stable(st_ff.shift_stage))
    else $error("shift register changed while deselected");

  chk_shift_capture: assert property (@(posedge CLK) disable iff (RST)
    (sclk_fall && !cs_n_s) |=> st_ff.shift_stage[0] == $past(din_s))
    else $error("falling shift clock did not capture data");

  chk_rise_no_shift: assert property (@(posedge CLK) disable iff (RST)
    (sclk_rise && !cs_fall) |=> $stable(st_ff.shift_stage))
    else $error("rising shift clock moved the register");

  chk_sout_update: assert property (@(posedge CLK) disable iff (RST)
    (sclk_rise && !cs_n_s) |=> SERIAL_OUT == $past(st_ff.shift_stage[SEGS-1]))
    else $error("serial out not updated on rising clock");

  chk_latch_hold: assert property (@(posedge CLK) disable iff (RST)
    (!load_s) |=> st_ff.latch == $past(st_ff.latch))
    else $error("latch moved while load low");

  chk_latch_fall: assert property (@(posedge CLK) disable iff (RST)
    ($past(load_s) && !load_s) |-> st_ff.latch == $past(st_ff.shift_stage))
    else $error("falling load did not keep the shift data");

  chk_extra_shift: assert property (@(posedge CLK) disable iff (RST)
    (cs_fall && !sclk_s) |=> st_ff.shift_stage[0] == $past(din_s))
    else $error("select edge with clock low did not shift");

  chk_seg_phase: assert property (@(posedge CLK) disable iff (RST)
    ##1 SEG_OUT == ($past(st_ff.latch) ^ {SEGS{BACKPLANE_OUT}}))
    else $error("segment phase does not follow latch");

  chk_static_dc: assert property (@(posedge CLK) disable iff (RST)
    (mode == slcd_pkg::SLCD_MODE_STATIC)[*2] |-> !BACKPLANE_OUT)
    else $error("backplane alternates in static mode");

  chk_ext_follow: assert property (@(posedge CLK) disable iff (RST)
    (mode == slcd_pkg::SLCD_MODE_EXT) |=> BACKPLANE_OUT == $past(bpin_s))
    else $error("backplane does not follow external clock");

endmodule

`default_nettype wire

// File: slcd_pkg.sv
/*
  slcd_pkg: constants shared by the serial segment driver files.
  assumes: included before slcd_sync and slcd_top.
*/
`default_nettype none

package slcd_pkg;

  // backplane mode selection
  typedef enum logic [1:0] {
    SLCD_MODE_INT    = 2'h0,
    SLCD_MODE_EXT    = 2'h1,
    SLCD_MODE_STATIC = 2'h2
  } slcd_mode_e;

  localparam int unsigned SLCD_SEG_DEFAULT   = 32;
  localparam int unsigned SLCD_DIV_RATIO     = 256;
  localparam int unsigned SLCD_DIV_WIDTH     = 8;
  localparam logic [7:0]  SLCD_DIV_RESET     = 8'h00;
  localparam int unsigned SLCD_SYNC_STAGES   = 2;
  localparam logic        SLCD_PIN_RESET     = 1'h0;
  localparam logic        SLCD_CS_RESET      = 1'h1;

endpackage

`default_nettype wire

// File: slcd_sync.sv
/*
  slcd_sync: two-flop synchroniser for a bundle of pin inputs.
  assumes: inputs are asynchronous to CLK; reset value per bit given.
*/
`timescale 1ns/10ps
`default_nettype none

module slcd_sync #(
  parameter int unsigned WIDTH = 4
) (
  // clock and reset
  input  wire logic             clk,
  input  wire logic             rst,
  // pins and synchronised levels
  input  wire logic [WIDTH-1:0] rst_val,
  input  wire logic [WIDTH-1:0] pin_in,
  output logic      [WIDTH-1:0] pin_sync
);

  logic [WIDTH-1:0] meta_ff;
  logic [WIDTH-1:0] sync_ff;

  // flops hold the pin level xor rst_val, so a plain zero reset reads back
  // as rst_val; this keeps the reset branch constant and glitch free
  genvar g;
  generate
    for (g = 0; g < WIDTH; g = g + 1) begin : g_bit
      always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
          meta_ff[g] <= 1'b0;
          sync_ff[g] <= 1'b0;
        end else begin
          meta_ff[g] <= pin_in[g] ^ rst_val[g];
          sync_ff[g] <= meta_ff[g];
        end
      end
    end
  endgenerate

  // undo the stored inversion; during reset and until the second clock edge after it this gives rst_val
  assign pin_sync = sync_ff ^ rst_val;

endmodule

`default_nettype wire

// File: slcd_ctrl_model.sv
/*
  slcd_ctrl_model: controller that drives the serial load pins.
  assumes: CLK is the bench clock; each pin level stands HOLD+1 cycles.
*/
`timescale 1ns/10ps
`default_nettype none

module slcd_ctrl_model #(
  parameter int HOLD = 4
) (
  // clock
  input  wire logic CLK,
  // serial load pins
  output logic      sdi,
  output logic      sck,
  output logic      cs_n,
  output logic      ld
);
  // -----------------------------------------------------------------
  // pin driver
  // -----------------------------------------------------------------
  // idle: clock high and deselected, so selecting adds no shift
  initial begin
    {sdi, sck, cs_n, ld} = 4'h6;
  end

  // three control lines plus one data line, changed together
  task automatic put(input logic [3:0] v);
    @(posedge CLK);
    {sdi, sck, cs_n, ld} <= v;
    repeat (HOLD) @(posedge CLK);
  endtask
endmodule

`default_nettype wire

// File: slcd_top_bench.sv
/*
  slcd_top_bench: self-checking bench for slcd_top with eight segments.
  assumes: slcd_pkg, slcd_sync, slcd_top and slcd_ctrl_model compiled.
*/
`timescale 1ns/10ps
`default_nettype none

module slcd_top_bench;
  localparam int unsigned N = 8;
  logic            clk = 1'h0;
  logic            rst = 1'h1;
  logic            osc = 1'h0;
  logic            bclk = 1'h0;
  logic [1:0]      strap = slcd_pkg::SLCD_MODE_INT;
  logic            sdi, sck, cs_n, ld, so, bp;
  logic [N-1:0]    seg, w;
  logic [N-1:0]    sr_e = '0;
  logic [N-1:0]    lat_e = '0;
  logic            so_e = 1'h0;
  logic            bp_e = 1'h0;
  logic            ld_e = 1'h0;
  logic            d;
  logic [N+1:0]    q[$];
  int              fail_count = 0;
  int              num_checks = 0;
  int              cyc = 0;
  event            look;

  always #5 clk = ~clk;

  slcd_ctrl_model i_slcd_ctrl_model (.CLK(clk), .sdi(sdi), .sck(sck),
    .cs_n(cs_n), .ld(ld));
  slcd_top #(.SEGS(N)) i_slcd_top (.CLK(clk), .RST(rst), .SERIAL_IN(sdi),
    .SHIFT_CLK(sck), .CHIP_SEL_N(cs_n), .LOAD(ld), .SERIAL_OUT(so),
    .OSC_TICK(osc), .BACKPLANE_CLOCK_IN(bclk), .OSCILLATOR_STRAP(strap),
    .BACKPLANE_OUT(bp), .SEG_OUT(seg));

  // -----------------------------------------------------------------
  // expectations and watcher
  // -----------------------------------------------------------------
  task automatic give_verdict();
    $display("checks %0d mismatches %0d", num_checks, fail_count);
    if (fail_count == 0 && num_checks > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask

  // waits out sync and output latency before the note is taken
  task automatic chk();
    repeat (6) @(posedge clk);
    #1;
    q.push_back({bp_e, so_e, lat_e ^ {N{bp_e}}});
    -> look;
  endtask

  always @(look) begin
    logic [N+1:0] e;
    while (q.size() > 0) begin
      e = q.pop_front();
      num_checks++;
      if ({bp, so, seg} !== e) begin
        fail_count++;
        $display("mismatch at %0t: got %h want %h", $time, {bp, so, seg}, e);
      end
    end
  end

  always @(posedge clk) begin
    cyc++;
    if (cyc == 12000) begin
      fail_count++;
      give_verdict();
    end
  end

  // -----------------------------------------------------------------
  // stimulus helpers
  // -----------------------------------------------------------------
  task automatic mv(input logic b);
    sr_e = {sr_e[N-2:0], b};
    so_e = sr_e[N-1];
    if (ld_e) lat_e = sr_e;
  endtask

  task automatic sh(input logic b);
    i_slcd_ctrl_model.put({b, 2'h0, ld_e});
    i_slcd_ctrl_model.put({b, 2'h2, ld_e});
    mv(b);
  endtask

  task automatic sel(input logic s);
    i_slcd_ctrl_model.put({2'h1, s, ld_e});
  endtask

  task automatic ldset(input logic l);
    ld_e = l;
    if (l) lat_e = sr_e;
    i_slcd_ctrl_model.put({3'h2, l});
  endtask

  task automatic tick(input int n);
    repeat (n) begin
      @(posedge clk) osc <= 1'h1;
      repeat (3) @(posedge clk);
      osc <= 1'h0;
      repeat (3) @(posedge clk);
    end
  endtask

  // -----------------------------------------------------------------
  // main sequence
  // -----------------------------------------------------------------
  initial begin
    repeat (3) @(posedge clk);
    rst <= 1'h0;
    w = N'($urandom(40636));
    chk();
    sel(1'h0);
    for (int i = N - 1; i >= 0; i--) sh(w[i]);
    chk();
    ldset(1'h1);
    chk();
    ldset(1'h0);
    // clock pulses while deselected must leave the register alone
    sel(1'h1);
    repeat (2) begin
      i_slcd_ctrl_model.put(4'ha);
      i_slcd_ctrl_model.put(4'he);
    end
    sel(1'h0);
    ldset(1'h1);
    ldset(1'h0);
    chk();
    // select falls with the clock low: one extra shift
    d = 1'($urandom());
    i_slcd_ctrl_model.put({d, 3'h6});
    i_slcd_ctrl_model.put({d, 3'h2});
    i_slcd_ctrl_model.put({d, 3'h0});
    i_slcd_ctrl_model.put({d, 3'h4});
    mv(d);
    ldset(1'h1);
    chk();
    for (int i = 0; i < 3; i++) begin
      sh(1'($urandom()));
      chk();
    end
    ldset(1'h0);
    for (int i = 0; i < 3; i++) sh(1'($urandom()));
    chk();
    tick(127);
    chk();
    tick(1);
    bp_e = 1'h1;
    chk();
    @(posedge clk) strap <= slcd_pkg::SLCD_MODE_EXT;
    bclk <= 1'h0;
    bp_e = 1'h0;
    chk();
    @(posedge clk) bclk <= 1'h1;
    bp_e = 1'h1;
    chk();
    @(posedge clk) strap <= slcd_pkg::SLCD_MODE_STATIC;
    bclk <= 1'h0;
    bp_e = 1'h0;
    chk();
    tick(300);
    chk();
    @(posedge clk) strap <= 2'h3;
    chk();
    give_verdict();
  end
endmodule

`default_nettype wire
